/* dcr_map.svh */
// Register indices, field positions and constants of the control bank
`ifndef DCR_MAP_SVH
`define DCR_MAP_SVH

`define DCR_OP_WRITE           8'h02
`define DCR_OP_READ            8'h03
`define DCR_HEAD_LAST          6'h0F
`define DCR_HEAD_BITS          6'h10
`define DCR_FRAME_LAST         6'h1F
`define DCR_FRAME_BITS         6'h20

`define DCR_REG_CTRL           4'h0
`define DCR_REG_COND           4'h1
`define DCR_REG_BOOST          4'h2
`define DCR_REG_INCLK          4'h3
`define DCR_REG_SECS           4'h4
`define DCR_REG_AUFMT          4'h5
`define DCR_REG_UPLD           4'h6
`define DCR_REG_UPADDR         4'h7

`define DCR_LEFT_INVERT_BIT    0
`define DCR_SOFT_RESET_BIT     2
`define DCR_WAV_EXIT_BIT       3
`define DCR_SW_POWERDOWN_BIT   4
`define DCR_TEST_ENABLE_BIT    5
`define DCR_STREAM_MODE_BIT    6
`define DCR_DATA_CLOCK_EDGE_BIT 8
`define DCR_DATA_BIT_ORDER_BIT 9
`define DCR_SHARED_SELECT_BIT  10
`define DCR_NATIVE_SERIAL_BIT  11
`define DCR_DOUBLER_BIT        15

`define DCR_CTRL_RESET         16'h0000
`define DCR_ANALOG_RESET       4'hC
`define DCR_VERSION_PAD        9'h000

`define DCR_X_LO               16'h1380
`define DCR_X_HI               16'h13FF
`define DCR_Y_LO               16'h4780
`define DCR_Y_HI               16'h47FF
`define DCR_I_LO               16'h8030
`define DCR_I_HI               16'h84FF
`define DCR_X_SLOT             4'hA
`define DCR_Y_SLOT             4'hB

`endif

/* dcr_pkg.sv */
// Shared types of the decoder control bank
package dcr_pkg;

  typedef enum logic [3:0] {
    DCR_IDLE = 4'h1,
    DCR_HEAD = 4'h2,
    DCR_DATA = 4'h4,
    DCR_DONE = 4'h8
  } dcr_state_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] data;
  } dcr_wr_t;

  typedef struct packed {
    logic       drv_pd;
    logic       int_pd;
    logic [1:0] atten;
  } dcr_analog_t;

  typedef struct packed {
    logic        valid;
    logic        wide;
    logic [10:0] idx;
  } dcr_slot_t;

endpackage

/* dcr_sync.sv */
// Two-stage synchroniser for the serial control port pins
module dcr_sync #(
  parameter logic [2:0] INIT = 3'h2
) (
  input  logic       clk,
  input  logic       rst,
  input  logic       ce,
  input  logic [2:0] d,
  output logic [2:0] q
);
  logic [2:0] meta_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= INIT;
      q      <= INIT;
    end else if (ce) begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

/* dcr_upload_ram.sv */
// Upload memory for program and data words, registered read
module dcr_upload_ram (
  input  logic        clk,
  input  logic        ce,
  input  logic        we,
  input  logic [10:0] waddr,
  input  logic [31:0] wdata,
  input  logic [10:0] raddr,
  output logic [31:0] rdata
);
  logic [31:0] mem [0:2047];

  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (ce) begin
      rdata <= mem[raddr];
    end
  end
endmodule

/* dcr_bank.sv */
// Control register bank with serial control port slave
// Overview of operation
// - Control bit 0 set inverts left channel; clear keeps channels in phase.
// - Writing 1 to control bit 2 soft-resets; the bit clears itself.
// - Host sets bit 3, sends zeros until device clears it, or 128.
// - Bit 4 selects software powerdown, weaker than hardware powerdown.
// - Data input test sequences are accepted only while bit 5 is set.
// - Bit 6 stream mode: speed varies up to 5% to keep buffer half full.
// - Control bit 8 picks data sampling edge: clear rising, set falling.
// - Bit 9 makes data bytes arrive LSB first; control port unaffected.
// - Bit 11 enables native modes; bit 10 shares select only with bit 11.
// - Status two-bit analog attenuation: 0, -6 dB, -12 dB; firmware-driven.
// - Status bit 3 powers down driver; bit 2 internal analog, firmware.
// - Boost amplitude bits 7..4, floor 3..0; active if amplitude nonzero.
// - Clock setting low fifteen bits give input clock in 2 kHz units.
// - Clock setting MSB enables clock doubling for inputs up to 15 MHz.
// - Elapsed seconds counter, cleared by soft reset; host writes twice.
// - Audio format reads half sample rate in 15..1, stereo flag bit 0.
// - Writing audio format changes playback sample rate at once.
// - Upload address first; 32-bit words as two writes, high half first.
// - Upload addresses map to X, Y and instruction RAM windows.
// - Each control port access carries exactly 16 data bits.
`include "dcr_map.svh"
module dcr_bank #(
  parameter logic [2:0] VERSION = 3'h6  // Arbitrary version code
) (
  input  logic                clk,
  input  logic                rst,
  input  logic                ce,
  input  logic                sck,
  input  logic                cs_n,
  input  logic                mosi,
  output logic                miso,
  output logic                miso_oe,
  input  logic                fw_cond_we,
  input  dcr_pkg::dcr_analog_t fw_cond,
  input  logic                wav_done,
  input  logic                sec_tick,
  input  logic                aud_we,
  input  logic [15:0]         aud_val,
  output logic                left_invert,
  output logic                soft_reset,
  output logic                sw_powerdown,
  output logic                test_enable,
  output logic                stream_mode,
  output logic                data_falling_edge,
  output logic                data_lsb_first,
  output logic                native_serial,
  output logic                shared_select,
  output dcr_pkg::dcr_analog_t analog,
  output logic                bass_enable,
  output logic [3:0]          boost_amp,
  output logic [3:0]          boost_floor,
  output logic [14:0]         inclk_units,
  output logic                clock_doubler,
  output logic [14:0]         half_rate,
  output logic                stereo,
  output logic                rate_load
);

  function automatic logic is_reg(input logic stb,
                                  input dcr_pkg::dcr_wr_t w,
                                  input logic [3:0] a);
    is_reg = stb && (w.addr == a);
  endfunction

  // Upload address to memory slot; dest Y is 0x0580, instr is 0x0030 up
  function automatic dcr_pkg::dcr_slot_t map_up(input logic [15:0] a);
    map_up = '0;
    if (a >= `DCR_X_LO && a <= `DCR_X_HI) begin
      map_up = '{1'b1, 1'b0, {`DCR_X_SLOT, a[6:0]}};
    end else if (a >= `DCR_Y_LO && a <= `DCR_Y_HI) begin
      map_up = '{1'b1, 1'b0, {`DCR_Y_SLOT, a[6:0]}};
    end else if (a >= `DCR_I_LO && a <= `DCR_I_HI) begin
      map_up = '{1'b1, 1'b1, a[10:0]};
    end
  endfunction

  logic [2:0]          pin_s;
  logic                sck_prev_q;
  logic                sck_s;
  logic                cs_s;
  logic                mosi_s;
  logic                rise;
  logic                fall;
  dcr_pkg::dcr_state_t state_q;
  logic [5:0]          cnt_q;
  logic [15:0]         sh_q;
  logic [15:0]         out_q;
  logic [15:0]         full;
  logic [3:0]          addr_q;
  logic                is_wr_q;
  logic                is_rd_q;
  logic                wr_stb_q;
  dcr_pkg::dcr_wr_t    wr_q;
  logic [15:0]         rd_word;
  logic [15:0]         mode_q;
  dcr_pkg::dcr_analog_t ana_q;
  logic [7:0]          boost_q;
  logic [15:0]         inclk_q;
  logic [15:0]         secs_q;
  logic [15:0]         aud_q;
  logic                rate_load_q;
  logic [15:0]         upaddr_q;
  logic [15:0]         ptr_q;
  logic                half_q;
  logic [15:0]         hi_q;
  dcr_pkg::dcr_slot_t  wslot;
  dcr_pkg::dcr_slot_t  rslot;
  logic                mem_we;
  logic [31:0]         mem_rdata;
  logic                w_ctrl;
  logic                w_upld;
  logic                w_upaddr;

  dcr_sync #(
    .INIT (3'h2)
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .d   ({sck, cs_n, mosi}),
    .q   (pin_s)
  );

  assign sck_s  = pin_s[2];
  assign cs_s   = pin_s[1];
  assign mosi_s = pin_s[0];
  assign rise   = sck_s & ~sck_prev_q;
  assign fall   = ~sck_s & sck_prev_q;
  assign full   = {sh_q[14:0], mosi_s};

  always_ff @(posedge clk) begin
    if (rst) begin
      sck_prev_q <= 1'b0;
    end else if (ce) begin
      sck_prev_q <= sck_s;
    end
  end

  // Frame sequencer: 16 header bits, then exactly 16 data bits
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= dcr_pkg::DCR_IDLE;
    end else if (ce) begin
      if (cs_s) begin
        state_q <= dcr_pkg::DCR_IDLE;
      end else begin
        unique case (state_q)
          dcr_pkg::DCR_IDLE: state_q <= dcr_pkg::DCR_HEAD;
          dcr_pkg::DCR_HEAD: begin
            if (rise && cnt_q == `DCR_HEAD_LAST) begin
              state_q <= dcr_pkg::DCR_DATA;
            end
          end
          dcr_pkg::DCR_DATA: begin
            if (rise && cnt_q == `DCR_FRAME_LAST) begin
              state_q <= dcr_pkg::DCR_DONE;
            end
          end
          dcr_pkg::DCR_DONE: state_q <= dcr_pkg::DCR_DONE;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
      sh_q  <= '0;
    end else if (ce) begin
      if (cs_s) begin
        cnt_q <= '0;
      end else if (rise && state_q != dcr_pkg::DCR_DONE) begin
        cnt_q <= cnt_q + 6'h01;
        sh_q  <= full;
      end
    end
  end

  // Header decode and read data shift-out
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_q  <= '0;
      is_wr_q <= 1'b0;
      is_rd_q <= 1'b0;
      out_q   <= '0;
    end else if (ce) begin
      if (state_q == dcr_pkg::DCR_HEAD && rise &&
          cnt_q == `DCR_HEAD_LAST) begin
        addr_q  <= full[3:0];
        is_wr_q <= full[15:8] == `DCR_OP_WRITE && full[7:4] == 4'h0;
        is_rd_q <= full[15:8] == `DCR_OP_READ && full[7:4] == 4'h0;
        out_q   <= (full[15:8] == `DCR_OP_READ && full[7:4] == 4'h0)
                   ? rd_word_for(full[3:0]) : 16'h0000;
      end else if (state_q == dcr_pkg::DCR_DATA && fall &&
                   cnt_q != `DCR_HEAD_BITS) begin
        out_q <= {out_q[14:0], 1'b0};
      end
    end
  end

  assign miso    = out_q[15];
  assign miso_oe = ~cs_s;

  // Write commits only after the 16th data bit
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_stb_q <= 1'b0;
      wr_q     <= '0;
    end else if (ce) begin
      wr_stb_q <= state_q == dcr_pkg::DCR_DATA && rise &&
                  cnt_q == `DCR_FRAME_LAST && is_wr_q;
      wr_q     <= '{addr_q, full};
    end
  end

  assign w_ctrl   = is_reg(wr_stb_q, wr_q, `DCR_REG_CTRL);
  assign w_upld   = is_reg(wr_stb_q, wr_q, `DCR_REG_UPLD);
  assign w_upaddr = is_reg(wr_stb_q, wr_q, `DCR_REG_UPADDR);

  function automatic logic [15:0] rd_word_for(input logic [3:0] a);
    rd_word_for = 16'h0000;
    case (a)
      `DCR_REG_CTRL:   rd_word_for = mode_q;
      `DCR_REG_COND:   rd_word_for = {`DCR_VERSION_PAD, VERSION, ana_q};
      `DCR_REG_BOOST:  rd_word_for = {8'h00, boost_q};
      `DCR_REG_INCLK:  rd_word_for = inclk_q;
      `DCR_REG_SECS:   rd_word_for = secs_q;
      `DCR_REG_AUFMT:  rd_word_for = aud_q;
      `DCR_REG_UPLD:   rd_word_for = rd_word;
      `DCR_REG_UPADDR: rd_word_for = upaddr_q;
      default:         rd_word_for = 16'h0000;
    endcase
  endfunction

  // Control bits; a host set wins over a same-cycle hardware clear
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_q <= `DCR_CTRL_RESET;
    end else if (ce) begin
      if (w_ctrl) begin
        mode_q <= wr_q.data;
      end else begin
        mode_q[`DCR_SOFT_RESET_BIT] <= 1'b0;
        if (wav_done) begin
          mode_q[`DCR_WAV_EXIT_BIT] <= 1'b0;
        end
      end
    end
  end

  assign left_invert       = mode_q[`DCR_LEFT_INVERT_BIT];
  assign soft_reset        = mode_q[`DCR_SOFT_RESET_BIT];
  assign sw_powerdown      = mode_q[`DCR_SW_POWERDOWN_BIT];
  assign test_enable       = mode_q[`DCR_TEST_ENABLE_BIT];
  assign stream_mode       = mode_q[`DCR_STREAM_MODE_BIT];
  assign data_falling_edge = mode_q[`DCR_DATA_CLOCK_EDGE_BIT];
  assign data_lsb_first    = mode_q[`DCR_DATA_BIT_ORDER_BIT];
  assign native_serial     = mode_q[`DCR_NATIVE_SERIAL_BIT];
  assign shared_select     = mode_q[`DCR_SHARED_SELECT_BIT] &
                             mode_q[`DCR_NATIVE_SERIAL_BIT];

  // Analog fields: firmware drives them, host write takes priority
  always_ff @(posedge clk) begin
    if (rst) begin
      ana_q <= `DCR_ANALOG_RESET;
    end else if (ce) begin
      if (is_reg(wr_stb_q, wr_q, `DCR_REG_COND)) begin
        ana_q <= wr_q.data[3:0];
      end else if (fw_cond_we) begin
        ana_q <= fw_cond;
      end
    end
  end

  assign analog = ana_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      boost_q <= '0;
    end else if (ce && is_reg(wr_stb_q, wr_q, `DCR_REG_BOOST)) begin
      boost_q <= wr_q.data[7:0];
    end
  end

  assign boost_amp   = boost_q[7:4];
  assign boost_floor = boost_q[3:0];
  assign bass_enable = |boost_q[7:4];

  // Soft reset forgets the clock setting; host must rewrite it
  always_ff @(posedge clk) begin
    if (rst) begin
      inclk_q <= '0;
    end else if (ce) begin
      if (is_reg(wr_stb_q, wr_q, `DCR_REG_INCLK)) begin
        inclk_q <= wr_q.data;
      end else if (soft_reset) begin
        inclk_q <= '0;
      end
    end
  end

  assign inclk_units   = inclk_q[14:0];
  assign clock_doubler = inclk_q[`DCR_DOUBLER_BIT];

  always_ff @(posedge clk) begin
    if (rst) begin
      secs_q <= '0;
    end else if (ce) begin
      if (is_reg(wr_stb_q, wr_q, `DCR_REG_SECS)) begin
        secs_q <= wr_q.data;
      end else if (soft_reset) begin
        secs_q <= '0;
      end else if (sec_tick) begin
        secs_q <= secs_q + 16'h0001;
      end
    end
  end

  // Audio format: decoder reports, host write forces a new rate
  always_ff @(posedge clk) begin
    if (rst) begin
      aud_q       <= '0;
      rate_load_q <= 1'b0;
    end else if (ce) begin
      rate_load_q <= is_reg(wr_stb_q, wr_q, `DCR_REG_AUFMT);
      if (is_reg(wr_stb_q, wr_q, `DCR_REG_AUFMT)) begin
        aud_q <= wr_q.data;
      end else if (aud_we) begin
        aud_q <= aud_val;
      end
    end
  end

  assign half_rate = aud_q[15:1];
  assign stereo    = aud_q[0];
  assign rate_load = rate_load_q;

  // Upload pointer: wide words pair high half then low half
  assign wslot  = map_up(ptr_q);
  assign rslot  = map_up(ptr_q);
  assign mem_we = w_upld && wslot.valid && (!wslot.wide || half_q);

  always_ff @(posedge clk) begin
    if (rst) begin
      upaddr_q <= '0;
      ptr_q    <= '0;
      half_q   <= 1'b0;
      hi_q     <= '0;
    end else if (ce) begin
      if (w_upaddr) begin
        upaddr_q <= wr_q.data;
        ptr_q    <= wr_q.data;
        half_q   <= 1'b0;
      end else if (w_upld) begin
        if (wslot.wide && !half_q) begin
          hi_q   <= wr_q.data;
          half_q <= 1'b1;
        end else begin
          ptr_q  <= ptr_q + 16'h0001;
          half_q <= 1'b0;
        end
      end
    end
  end

  dcr_upload_ram u_ram (
    .clk   (clk),
    .ce    (ce),
    .we    (mem_we),
    .waddr (wslot.idx),
    .wdata (wslot.wide ? {hi_q, wr_q.data} : {16'h0000, wr_q.data}),
    .raddr (rslot.idx),
    .rdata (mem_rdata)
  );

  assign rd_word = (rslot.wide && !half_q) ? mem_rdata[31:16]
                                           : mem_rdata[15:0];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  AST_LEFT_INVERT: assert property (
    ce && w_ctrl |=> left_invert == $past(wr_q.data[0]))
    else $error("left invert does not follow control write");
  AST_SRST_CLEARS: assert property (
    ce && soft_reset && !w_ctrl |=> !soft_reset)
    else $error("soft reset bit did not clear itself");
  AST_SRST_EFFECT: assert property (
    ce && soft_reset && !wr_stb_q |=> secs_q == 16'h0000 &&
    inclk_q == 16'h0000)
    else $error("soft reset left time or clock setting");
  AST_WAV_EXIT: assert property (
    ce && wav_done && !w_ctrl |=> !mode_q[`DCR_WAV_EXIT_BIT])
    else $error("wav exit bit not cleared by decoder");
  AST_SHARE: assert property (
    ce && w_ctrl |=> shared_select ==
    ($past(wr_q.data[`DCR_SHARED_SELECT_BIT]) &&
     $past(wr_q.data[`DCR_NATIVE_SERIAL_BIT])))
    else $error("shared select does not follow native mode");
  AST_BASS: assert property (
    ce && is_reg(wr_stb_q, wr_q, `DCR_REG_BOOST) |=>
    bass_enable == ($past(wr_q.data[7:4]) != 4'h0))
    else $error("bass enable does not follow amplitude");
  AST_DOUBLER: assert property (
    ce && is_reg(wr_stb_q, wr_q, `DCR_REG_INCLK) |=>
    clock_doubler == $past(wr_q.data[15]) &&
    inclk_units == $past(wr_q.data[14:0]))
    else $error("clock setting not taken");
  AST_RATE: assert property (
    ce && is_reg(wr_stb_q, wr_q, `DCR_REG_AUFMT) |=>
    rate_load && half_rate == $past(wr_q.data[15:1]))
    else $error("sample rate write not applied");
  AST_WORD_PAIR: assert property (
    ce && w_upld && wslot.wide && !half_q |=> half_q &&
    ptr_q == $past(ptr_q))
    else $error("pointer moved on first half of wide word");
  AST_PTR_ADV: assert property (
    ce && mem_we && !w_upaddr |=> ptr_q == $past(ptr_q) + 16'h0001)
    else $error("pointer not advanced after full word");
  AST_FRAME_LEN: assert property (
    wr_stb_q |-> cnt_q == `DCR_FRAME_BITS)
    else $error("write committed before 16 data bits");

  COV_CTRL_WRITE: cover property (ce && w_ctrl);
  COV_READ_FRAME: cover property (is_rd_q && state_q == dcr_pkg::DCR_DONE);
  COV_WIDE_WORD:  cover property (mem_we && wslot.wide);
  COV_SOFT_RESET: cover property (ce && soft_reset);

endmodule

/* dcr_host_model.sv */
// Host model that drives frames on the serial control port
module dcr_host_model (
  input  wire logic clk,
  output logic      sck,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso,
  input  wire logic miso_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 5;

  initial begin
    sck  = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // Mode 0 frame: op, index, 16 data bits, MSB first
  task automatic xfer(input  logic [7:0]  op,
                      input  logic [7:0]  idx,
                      input  logic [15:0] wd,
                      output logic [15:0] rd);
    logic [31:0] frame;
    frame = {op, idx, wd};
    rd    = 16'hxxxx;
    @(posedge clk);
    cs_n <= 1'b0;
    for (int i = 31; i >= 0; i--) begin
      repeat (HALF) @(posedge clk);
      mosi <= frame[i];
      sck  <= 1'b0;
      repeat (HALF) @(posedge clk);
      // Released line reads as unknown
      if (i < 16) begin
        rd[i] = miso_oe ? miso : 1'bx;
      end
      sck <= 1'b1;
    end
    repeat (HALF) @(posedge clk);
    sck <= 1'b0;
    repeat (HALF) @(posedge clk);
    cs_n <= 1'b1;
    mosi <= ~mosi;
    repeat (6) @(posedge clk);
  endtask
endmodule

/* dcr_bank_tb.sv */
// Self-checking bench for the decoder control register bank
`include "dcr_map.svh"
module dcr_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] VER = 3'h6;  // Arbitrary version code
  localparam int LIMIT = 60000;
  logic clk, rst, ce, sck, cs_n, mosi, miso, miso_oe;
  logic fw_cond_we, wav_done, sec_tick, aud_we, rate_load;
  logic left_invert, soft_reset, sw_powerdown, test_enable, stream_mode;
  logic data_falling_edge, data_lsb_first, native_serial, shared_select;
  logic bass_enable, clock_doubler, stereo;
  logic [3:0] boost_amp, boost_floor;
  logic [14:0] inclk_units, half_rate;
  logic [15:0] aud_val, rd;
  dcr_pkg::dcr_analog_t fw_cond, analog;
  int bad_count, compares, sr_count, rl_count, cycles;

  dcr_bank #(.VERSION(VER)) dut_u (
    .clk(clk), .rst(rst), .ce(ce), .sck(sck), .cs_n(cs_n), .mosi(mosi),
    .miso(miso), .miso_oe(miso_oe), .fw_cond_we(fw_cond_we),
    .fw_cond(fw_cond), .wav_done(wav_done), .sec_tick(sec_tick),
    .aud_we(aud_we), .aud_val(aud_val), .left_invert(left_invert),
    .soft_reset(soft_reset), .sw_powerdown(sw_powerdown),
    .test_enable(test_enable), .stream_mode(stream_mode),
    .data_falling_edge(data_falling_edge),
    .data_lsb_first(data_lsb_first), .native_serial(native_serial),
    .shared_select(shared_select), .analog(analog),
    .bass_enable(bass_enable), .boost_amp(boost_amp),
    .boost_floor(boost_floor), .inclk_units(inclk_units),
    .clock_doubler(clock_doubler), .half_rate(half_rate),
    .stereo(stereo), .rate_load(rate_load));

  dcr_host_model host_u (
    .clk(clk), .sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (soft_reset === 1'b1) sr_count++;
    if (rate_load === 1'b1) rl_count++;
    if (cycles > LIMIT) begin
      bad_count++;
      close_out();
    end
  end

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string m);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    logic [15:0] unused;
    host_u.xfer(`DCR_OP_WRITE, {4'h0, a}, d, unused);
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [15:0] exp,
                       input string m);
    host_u.xfer(`DCR_OP_READ, {4'h0, a}, 16'h0000, rd);
    chk(rd, exp, m);
  endtask

  task automatic t_reset();
    chk({left_invert, soft_reset, sw_powerdown, test_enable, stream_mode,
         data_falling_edge, data_lsb_first, native_serial, shared_select,
         clock_doubler, stereo, bass_enable, 4'h0}, 16'h0000,
        "idle outs");
    chk({12'h000, analog}, 16'h000C, "analog idle");
    rdchk(`DCR_REG_COND, {9'h000, VER, 4'hC}, "status idle");
    rdchk(4'h8, 16'h0000, "unmapped read");
  endtask

  task automatic t_ctrl();
    int bits [7] = '{0, 4, 5, 6, 8, 9, 11};
    logic [15:0] v;
    for (int k = 0; k < 7; k++) begin
      v = 16'h0001 << bits[k];
      wr(`DCR_REG_CTRL, v);
      rdchk(`DCR_REG_CTRL, v, "control readback");
      chk({4'h0, native_serial, 1'b0, data_lsb_first, data_falling_edge,
           1'b0, stream_mode, test_enable, sw_powerdown, 3'h0, left_invert},
          v, "control outs");
    end
    wr(`DCR_REG_CTRL, 16'h0400);
    chk({15'h0000, shared_select}, 16'h0000, "share alone");
    wr(`DCR_REG_CTRL, 16'h0C00);
    chk({15'h0000, shared_select}, 16'h0001, "share native");
  endtask

  task automatic t_soft();
    wr(`DCR_REG_INCLK, 16'h9964);
    chk({1'b0, inclk_units}, 16'h1964, "clock units");
    chk({15'h0000, clock_doubler}, 16'h0001, "doubler");
    wr(`DCR_REG_SECS, 16'h0005);
    wr(`DCR_REG_SECS, 16'h0005);
    sec_tick <= 1'b1;
    @(posedge clk);
    sec_tick <= 1'b0;
    rdchk(`DCR_REG_SECS, 16'h0006, "seconds count");
    sr_count = 0;
    wr(`DCR_REG_CTRL, 16'h0004);
    chk(sr_count[15:0], 16'h0001, "soft reset pulse");
    rdchk(`DCR_REG_CTRL, 16'h0000, "reset bit clears");
    rdchk(`DCR_REG_SECS, 16'h0000, "seconds cleared");
    wr(`DCR_REG_INCLK, 16'h3000);
    chk({1'b0, inclk_units}, 16'h3000, "clock rewritten");
  endtask

  task automatic t_misc();
    wr(`DCR_REG_CTRL, 16'h0008);
    rdchk(`DCR_REG_CTRL, 16'h0008, "wav exit set");
    wav_done <= 1'b1;
    @(posedge clk);
    wav_done <= 1'b0;
    rdchk(`DCR_REG_CTRL, 16'h0000, "wav exit done");
    wr(`DCR_REG_BOOST, 16'h00A3);
    chk({7'h00, bass_enable, boost_amp, boost_floor}, 16'h01A3,
        "boost on");
    wr(`DCR_REG_BOOST, 16'h0005);
    chk({15'h0000, bass_enable}, 16'h0000, "boost off");
    rl_count = 0;
    wr(`DCR_REG_AUFMT, 16'hAC45);
    chk({half_rate, stereo}, 16'hAC45, "format outs");
    chk(rl_count[15:0], 16'h0001, "rate load");
    aud_val <= 16'h3E80;
    aud_we  <= 1'b1;
    @(posedge clk);
    aud_we  <= 1'b0;
    rdchk(`DCR_REG_AUFMT, 16'h3E80, "format report");
    fw_cond    <= 4'h3;
    fw_cond_we <= 1'b1;
    @(posedge clk);
    fw_cond_we <= 1'b0;
    @(posedge clk);
    chk({12'h000, analog}, 16'h0003, "firmware analog");
    wr(`DCR_REG_COND, 16'hFFF8);
    rdchk(`DCR_REG_COND, {9'h000, VER, 4'h8}, "status write");
  endtask

  task automatic t_upload();
    logic [15:0] base [2] = '{16'h1380, 16'h47FE};
    wr(`DCR_REG_UPADDR, 16'h8030);
    wr(`DCR_REG_UPLD, 16'h1234);
    wr(`DCR_REG_UPLD, 16'h5678);
    wr(`DCR_REG_UPADDR, 16'h8030);
    rdchk(`DCR_REG_UPLD, 16'h1234, "instr high half");
    for (int k = 0; k < 2; k++) begin
      wr(`DCR_REG_UPADDR, base[k]);
      wr(`DCR_REG_UPLD, 16'hBEEF);
      wr(`DCR_REG_UPLD, 16'hC0DE);
      wr(`DCR_REG_UPADDR, base[k] + 16'h0001);
      rdchk(`DCR_REG_UPLD, 16'hC0DE, "data word advance");
    end
  endtask

  // Refused op, clock enable freeze and a reset in mid-run
  task automatic t_freeze();
    logic [15:0] unused;
    host_u.xfer(8'h04, 8'h00, 16'h0001, unused);
    chk({15'h0000, left_invert}, 16'h0000, "unknown op");
    ce       <= 1'b0;
    sec_tick <= 1'b1;
    repeat (2) @(posedge clk);
    ce       <= 1'b1;
    @(posedge clk);
    sec_tick <= 1'b0;
    rdchk(`DCR_REG_SECS, 16'h0001, "frozen tick");
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rdchk(`DCR_REG_INCLK, 16'h0000, "reset clock");
  endtask

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    fw_cond_we = 1'b0;
    fw_cond = 4'h0;
    wav_done = 1'b0;
    sec_tick = 1'b0;
    aud_we = 1'b0;
    aud_val = 16'h0000;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_ctrl();
    t_soft();
    t_misc();
    t_upload();
    t_freeze();
    close_out();
  end
endmodule
